// ### hw/dsl_top.sv
// dual 14-bit converter serial loader with register access over AXI4-Lite
`timescale 1ns/100ps
`include "dsl_defines.svh"
module dsl_top (
    // system
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // serial link
    input  wire logic        serial_clk,
    input  wire logic        serial_in,
    input  wire logic        select_load_n,
    output logic             serial_out,
    // clear input
    input  wire logic        async_zero_in,
    // converter side
    output logic [13:0]      dac_code_a,
    output logic [13:0]      dac_code_b,
    output logic [1:0]       dac_fast,
    output logic [1:0]       dac_shutdown
);
    ////////////////////////////////////////////////////////////////////////////
    // link logic and crossing
    dsl_link_if lnk ();

    dsl_link u_link (
        .serial_clk    (serial_clk),
        .aresetn       (aresetn),
        .serial_in     (serial_in),
        .select_load_n (select_load_n),
        .lnk           (lnk)
    );

    // comes straight from the top shift stage
    assign serial_out = lnk.ser_out;

    logic        sel_s1_r;
    logic        sel_s2_r;
    logic        sel_s3_r;
    logic        clr_s1_r;
    logic        clr_s2_r;
    logic [23:0] last_word_r;
    logic [23:0] last_word_nxt;
    logic [7:0]  frame_cnt_r;
    logic [7:0]  frame_cnt_nxt;
    logic        go_r;
    logic        go_nxt;
    logic        ctrl_en_r;
    logic        ctrl_en_nxt;
    logic        sw_clr_r;
    logic        sw_clr_nxt;
    logic        sel_rise;

    // the strobe is the handshake: the shifter is frozen while it is high,
    // so the word is stable when the synchronised rise is seen here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_s1_r <= 1'b1;
            sel_s2_r <= 1'b1;
            sel_s3_r <= 1'b1;
            clr_s1_r <= 1'b0;
            clr_s2_r <= 1'b0;
        end else begin
            sel_s1_r <= select_load_n;
            sel_s2_r <= sel_s1_r;
            sel_s3_r <= sel_s2_r;
            clr_s1_r <= async_zero_in;
            clr_s2_r <= clr_s1_r;
        end
    end

    assign sel_rise = sel_s2_r & ~sel_s3_r;

    always_comb begin
        last_word_nxt = last_word_r;
        frame_cnt_nxt = frame_cnt_r;
        go_nxt        = 1'b0;
        if (sel_rise && ctrl_en_r) begin
            // only the low 24 bits count; a 32-bit word drops its top byte
            last_word_nxt = lnk.word[23:0];
            frame_cnt_nxt = frame_cnt_r + 8'h01;
            go_nxt        = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_word_r <= 24'h000000;
            frame_cnt_r <= 8'h00;
            go_r        <= 1'b0;
        end else begin
            last_word_r <= last_word_nxt;
            frame_cnt_r <= frame_cnt_nxt;
            go_r        <= go_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command decode and channel state
    logic [3:0]               cmd;
    logic [3:0]               adr;
    logic [`DSL_CODE_W-1:0]   data;
    logic                     adr_ok;
    logic                     zero_codes;
    dsl_pkg::dsl_chan_t       ch_r [2];
    dsl_pkg::dsl_chan_t       ch_nxt [2];

    assign cmd  = last_word_r[`DSL_CMD_HI:`DSL_CMD_LO];
    assign adr  = last_word_r[`DSL_ADR_HI:`DSL_ADR_LO];
    assign data = last_word_r[`DSL_DATA_HI:`DSL_DATA_LO];
    assign adr_ok = (adr == `DSL_ADR_A) || (adr == `DSL_ADR_B)
                    || (adr == `DSL_ADR_BOTH);
    assign zero_codes = clr_s2_r | sw_clr_r;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_chan
            localparam logic [3:0] MY_ADR = (g == 0) ? `DSL_ADR_A : `DSL_ADR_B;
            logic hit;

            assign hit = (adr == MY_ADR) || (adr == `DSL_ADR_BOTH);

            always_comb begin
                ch_nxt[g] = ch_r[g];
                if (go_r && adr_ok) begin
                    case (cmd)
                        `DSL_CMD_LOAD: begin
                            if (hit) begin
                                ch_nxt[g].in_code = data;
                            end
                        end
                        `DSL_CMD_UPD: begin
                            if (hit) begin
                                ch_nxt[g].out_code = ch_r[g].in_code;
                                ch_nxt[g].pd       = 1'b0;
                            end
                        end
                        `DSL_CMD_LOAD_ALL: begin
                            // every channel updates; only the addressed one loads
                            if (hit) begin
                                ch_nxt[g].in_code  = data;
                                ch_nxt[g].out_code = data;
                            end else begin
                                ch_nxt[g].out_code = ch_r[g].in_code;
                            end
                            ch_nxt[g].pd = 1'b0;
                        end
                        `DSL_CMD_LOAD_UPD: begin
                            if (hit) begin
                                ch_nxt[g].in_code  = data;
                                ch_nxt[g].out_code = data;
                                ch_nxt[g].pd       = 1'b0;
                            end
                        end
                        `DSL_CMD_PWR_DN: begin
                            // speed stays as it is through shutdown
                            if (hit) begin
                                ch_nxt[g].pd = 1'b1;
                            end
                        end
                        `DSL_CMD_FAST: begin
                            if (hit) begin
                                ch_nxt[g].fast = 1'b1;
                            end
                        end
                        `DSL_CMD_SLOW: begin
                            if (hit) begin
                                ch_nxt[g].fast = 1'b0;
                            end
                        end
                        default: begin
                            // no operation and reserved codes change nothing
                            ch_nxt[g] = ch_r[g];
                        end
                    endcase
                end
                if (zero_codes) begin
                    ch_nxt[g].in_code  = '0;
                    ch_nxt[g].out_code = '0;
                end
            end

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    ch_r[g] <= '0;
                end else begin
                    ch_r[g] <= ch_nxt[g];
                end
            end
        end
    endgenerate

    assign dac_code_a   = ch_r[0].out_code;
    assign dac_code_b   = ch_r[1].out_code;
    assign dac_fast     = {ch_r[1].fast, ch_r[0].fast};
    assign dac_shutdown = {ch_r[1].pd, ch_r[0].pd};

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite write side
    dsl_pkg::dsl_wr_state_t ws_r;
    dsl_pkg::dsl_wr_state_t ws_nxt;
    logic        aw_hold_r;
    logic        aw_hold_nxt;
    logic        w_hold_r;
    logic        w_hold_nxt;
    logic [3:0]  waddr_r;
    logic [3:0]  waddr_nxt;
    logic [31:0] wdata_r;
    logic [31:0] wdata_nxt;
    logic        wstrb0_r;
    logic        wstrb0_nxt;
    logic        awready_nxt;
    logic        wready_nxt;
    logic        bvalid_nxt;
    logic [1:0]  bresp_nxt;

    always_comb begin
        ws_nxt      = ws_r;
        aw_hold_nxt = aw_hold_r;
        w_hold_nxt  = w_hold_r;
        waddr_nxt   = waddr_r;
        wdata_nxt   = wdata_r;
        wstrb0_nxt  = wstrb0_r;
        bvalid_nxt  = s_axi_bvalid;
        bresp_nxt   = s_axi_bresp;
        ctrl_en_nxt = ctrl_en_r;
        sw_clr_nxt  = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_nxt = 1'b1;
            waddr_nxt   = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_nxt = 1'b1;
            wdata_nxt  = s_axi_wdata;
            wstrb0_nxt = s_axi_wstrb[0];
        end
        case (ws_r)
            dsl_pkg::WS_IDLE: begin
                if (aw_hold_r && w_hold_r) begin
                    aw_hold_nxt = 1'b0;
                    w_hold_nxt  = 1'b0;
                    bvalid_nxt  = 1'b1;
                    bresp_nxt   = `DSL_RESP_OKAY;
                    ws_nxt      = dsl_pkg::WS_RESP;
                    case ({waddr_r[3:2], 2'b00})
                        `DSL_REG_CTRL: begin
                            if (wstrb0_r) begin
                                ctrl_en_nxt = wdata_r[`DSL_CTRL_EN_BIT];
                                sw_clr_nxt  = wdata_r[`DSL_CTRL_CLR_BIT];
                            end
                        end
                        `DSL_REG_CH_A, `DSL_REG_CH_B, `DSL_REG_LAST: begin
                            bresp_nxt = `DSL_RESP_OKAY;
                        end
                        default: begin
                            bresp_nxt = `DSL_RESP_SLVERR;
                        end
                    endcase
                end
            end
            dsl_pkg::WS_RESP: begin
                if (s_axi_bready) begin
                    bvalid_nxt = 1'b0;
                    ws_nxt     = dsl_pkg::WS_IDLE;
                end
            end
            default: begin
                ws_nxt = dsl_pkg::WS_IDLE;
            end
        endcase
        // one write under way at a time
        awready_nxt = ~aw_hold_nxt & (ws_nxt == dsl_pkg::WS_IDLE);
        wready_nxt  = ~w_hold_nxt & (ws_nxt == dsl_pkg::WS_IDLE);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ws_r          <= dsl_pkg::WS_IDLE;
            aw_hold_r     <= 1'b0;
            w_hold_r      <= 1'b0;
            waddr_r       <= 4'h0;
            wdata_r       <= 32'h00000000;
            wstrb0_r      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `DSL_RESP_OKAY;
            ctrl_en_r     <= `DSL_CTRL_EN_RST;
            sw_clr_r      <= 1'b0;
        end else begin
            ws_r          <= ws_nxt;
            aw_hold_r     <= aw_hold_nxt;
            w_hold_r      <= w_hold_nxt;
            waddr_r       <= waddr_nxt;
            wdata_r       <= wdata_nxt;
            wstrb0_r      <= wstrb0_nxt;
            s_axi_awready <= awready_nxt;
            s_axi_wready  <= wready_nxt;
            s_axi_bvalid  <= bvalid_nxt;
            s_axi_bresp   <= bresp_nxt;
            ctrl_en_r     <= ctrl_en_nxt;
            sw_clr_r      <= sw_clr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite read side
    dsl_pkg::dsl_rd_state_t rs_r;
    dsl_pkg::dsl_rd_state_t rs_nxt;
    logic        arready_nxt;
    logic        rvalid_nxt;
    logic [31:0] rdata_nxt;
    logic [1:0]  rresp_nxt;

    function automatic logic [31:0] chan_word(input dsl_pkg::dsl_chan_t c);
        logic [31:0] w;
        w = 32'h00000000;
        w[`DSL_CODE_W-1:0] = c.out_code;
        w[`DSL_ST_IN_LO+`DSL_CODE_W-1:`DSL_ST_IN_LO] = c.in_code;
        w[`DSL_ST_FAST_BIT] = c.fast;
        w[`DSL_ST_PD_BIT] = c.pd;
        return w;
    endfunction

    always_comb begin
        rs_nxt      = rs_r;
        rvalid_nxt  = s_axi_rvalid;
        rdata_nxt   = s_axi_rdata;
        rresp_nxt   = s_axi_rresp;
        arready_nxt = s_axi_arready;
        case (rs_r)
            dsl_pkg::RS_IDLE: begin
                arready_nxt = 1'b1;
                if (s_axi_arvalid && s_axi_arready) begin
                    arready_nxt = 1'b0;
                    rvalid_nxt  = 1'b1;
                    rresp_nxt   = `DSL_RESP_OKAY;
                    rs_nxt      = dsl_pkg::RS_DATA;
                    case ({s_axi_araddr[3:2], 2'b00})
                        `DSL_REG_CTRL: rdata_nxt = {31'h00000000, ctrl_en_r};
                        `DSL_REG_CH_A: rdata_nxt = chan_word(ch_r[0]);
                        `DSL_REG_CH_B: rdata_nxt = chan_word(ch_r[1]);
                        `DSL_REG_LAST: rdata_nxt = {frame_cnt_r, last_word_r};
                        default: begin
                            rdata_nxt = 32'h00000000;
                            rresp_nxt = `DSL_RESP_SLVERR;
                        end
                    endcase
                end
            end
            dsl_pkg::RS_DATA: begin
                arready_nxt = 1'b0;
                if (s_axi_rready) begin
                    rvalid_nxt  = 1'b0;
                    arready_nxt = 1'b1;
                    rs_nxt      = dsl_pkg::RS_IDLE;
                end
            end
            default: begin
                rs_nxt = dsl_pkg::RS_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rs_r          <= dsl_pkg::RS_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `DSL_RESP_OKAY;
        end else begin
            rs_r          <= rs_nxt;
            s_axi_arready <= arready_nxt;
            s_axi_rvalid  <= rvalid_nxt;
            s_axi_rdata   <= rdata_nxt;
            s_axi_rresp   <= rresp_nxt;
        end
    end
endmodule

// ### hw/dsl_defines.svh
// offsets, field positions, codes and reset values of the dual converter loader
`ifndef DSL_DEFINES_SVH
`define DSL_DEFINES_SVH

// serial word layout
`define DSL_SR_W          32
`define DSL_CODE_W        14
`define DSL_CMD_HI        23
`define DSL_CMD_LO        20
`define DSL_ADR_HI        19
`define DSL_ADR_LO        16
`define DSL_DATA_HI       15
`define DSL_DATA_LO       2

// command field codes
`define DSL_CMD_LOAD      4'h0
`define DSL_CMD_UPD       4'h1
`define DSL_CMD_LOAD_ALL  4'h2
`define DSL_CMD_LOAD_UPD  4'h3
`define DSL_CMD_PWR_DN    4'h4
`define DSL_CMD_FAST      4'h5
`define DSL_CMD_SLOW      4'h6
`define DSL_CMD_NOP       4'hF

// address field codes
`define DSL_ADR_A         4'h0
`define DSL_ADR_B         4'h1
`define DSL_ADR_BOTH      4'hF

// register byte offsets
`define DSL_REG_CTRL      4'h0
`define DSL_REG_CH_A      4'h4
`define DSL_REG_CH_B      4'h8
`define DSL_REG_LAST      4'hC

// control register fields and reset value
`define DSL_CTRL_EN_BIT   0
`define DSL_CTRL_CLR_BIT  1
`define DSL_CTRL_EN_RST   1'b1

// channel status register fields
`define DSL_ST_IN_LO      16
`define DSL_ST_FAST_BIT   30
`define DSL_ST_PD_BIT     31

// last word register field
`define DSL_LAST_CNT_LO   24

// bus responses
`define DSL_RESP_OKAY     2'h0
`define DSL_RESP_SLVERR   2'h2

`endif

// ### hw/dsl_pkg.sv
// types shared by the dual converter loader
package dsl_pkg;
    typedef enum {WS_IDLE, WS_RESP} dsl_wr_state_t;
    typedef enum {RS_IDLE, RS_DATA} dsl_rd_state_t;
    typedef struct packed {
        logic [13:0] in_code;
        logic [13:0] out_code;
        logic        fast;
        logic        pd;
    } dsl_chan_t;
endpackage

// ### hw/dsl_link_if.sv
// carrier between the serial link logic and the core
`timescale 1ns/100ps
interface dsl_link_if;
    logic [31:0] word;
    logic        ser_out;
    modport link (output word, output ser_out);
    modport core (input word, input ser_out);
endinterface

// ### hw/dsl_link.sv
// serial shift register on the link clock
`timescale 1ns/100ps
`include "dsl_defines.svh"
module dsl_link (
    // link clock and reset
    input  wire logic serial_clk,
    input  wire logic aresetn,
    // link pins
    input  wire logic serial_in,
    input  wire logic select_load_n,
    // to core
    dsl_link_if.link  lnk
);
    logic                 rst_s1_r;
    logic                 rst_s2_r;
    logic [`DSL_SR_W-1:0] sr_r;
    logic [`DSL_SR_W-1:0] sr_nxt;

    // reset level brought into the link domain; clears the shifter from the third link edge
    always_ff @(posedge serial_clk) begin
        rst_s1_r <= aresetn;
        rst_s2_r <= rst_s1_r;
    end

    always_comb begin
        sr_nxt = sr_r;
        if (!rst_s2_r) begin
            sr_nxt = '0;
        end else if (!select_load_n) begin
            // first bit in ends up at the top
            sr_nxt = {sr_r[`DSL_SR_W-2:0], serial_in};
        end
    end

    always_ff @(posedge serial_clk) begin
        sr_r <= sr_nxt;
    end

    assign lnk.word    = sr_r;
    assign lnk.ser_out = sr_r[`DSL_SR_W-1];
endmodule

// ### test/dsl_chk_assertions.sv
// concurrent checks on the ports of the dual converter loader
`timescale 1ns/100ps
module dsl_chk (
    // system
    input wire logic        aclk,
    input wire logic        aresetn,
    // bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // link and converter
    input wire logic        select_load_n,
    input wire logic        async_zero_in,
    input wire logic [13:0] dac_code_a,
    input wire logic [13:0] dac_code_b,
    input wire logic [1:0]  dac_fast,
    input wire logic [1:0]  dac_shutdown
);
    ////////////////////////////////////////
    // cycles since the last cause that may move the outputs; 8 covers sync plus decode
    logic       sel_q_r;
    logic [3:0] since_r;
    always_ff @(posedge aclk) begin
        sel_q_r <= select_load_n;
        if (!aresetn || (select_load_n && !sel_q_r) || async_zero_in || s_axi_wvalid)
            since_r <= 4'h0;
        else if (since_r != 4'hF)
            since_r <= since_r + 4'h1;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////
    property p_rst;
        $rose(aresetn) |-> dac_code_a == 14'h0 && dac_code_b == 14'h0 && dac_fast == 2'h0
            && dac_shutdown == 2'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    property p_clr;
        async_zero_in [*3] |-> ##2 (dac_code_a == 14'h0 && dac_code_b == 14'h0);
    endproperty
    a_clr: assert property (p_clr) else $error("clear did not zero the codes");
    property p_code;
        ($changed(dac_code_a) || $changed(dac_code_b)) |-> since_r < 4'h8;
    endproperty
    a_code: assert property (p_code) else $error("code moved without a command");
    property p_fast;
        $changed(dac_fast) |-> since_r < 4'h8;
    endproperty
    a_fast: assert property (p_fast) else $error("speed moved without a command");
    property p_shut;
        $changed(dac_shutdown) |-> since_r < 4'h8;
    endproperty
    a_shut: assert property (p_shut) else $error("shutdown moved without a command");
    property p_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
    endproperty
    a_wr: assert property (p_wr) else $error("write response missing");
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rd;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd: assert property (p_rd) else $error("read data missing");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
endmodule
bind dsl_top dsl_chk chk_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .select_load_n(select_load_n),
    .async_zero_in(async_zero_in), .dac_code_a(dac_code_a), .dac_code_b(dac_code_b),
    .dac_fast(dac_fast), .dac_shutdown(dac_shutdown));

// ### test/dsl_host_model.sv
// serial host that loads words into the converter link
`timescale 1ns/100ps
module dsl_host_model (
    // link pins
    output logic      serial_clk,
    output logic      serial_in,
    output logic      select_load_n,
    input  wire logic serial_out
);
    initial begin
        serial_clk    = 1'b0;
        serial_in     = 1'b0;
        select_load_n = 1'b1;
    end
    ////////////////////////////////////////
    // clock pulses with the strobe high, only so the link domain sees its reset
    task automatic pump(input int n);
        repeat (n) begin
            #62.5 serial_clk = 1'b1;
            #62.5 serial_clk = 1'b0;
        end
    endtask
    // so collects serial_out just before each rise, i.e. the old word from its top
    task automatic send(input logic [31:0] w, input int n, output logic [31:0] so);
        so = 32'h0;
        serial_clk = 1'b0;
        #20 select_load_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = w[i];
            #62.5 so = {so[30:0], serial_out};
            serial_clk = 1'b1;
            #62.5 serial_clk = 1'b0;
        end
        #20 select_load_n = 1'b1;
        serial_in = ~serial_in;
        #60;
    endtask
endmodule

// ### test/testbench.sv
// self-checking bench for the dual converter loader
`timescale 1ns/100ps
module testbench;
    typedef struct packed {
        logic [5:0]  n;
        logic [31:0] w;
        logic [31:0] o;
    } dsl_row_t;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        awvalid, wvalid, bready, arvalid, rready, clr;
    logic [3:0]  awaddr, araddr;
    logic [31:0] wdata, sh, so, d;
    logic        awready, wready, bvalid, arready, rvalid, sclk, sin, sel_n, sout;
    logic [1:0]  bresp, rresp, dac_fast, dac_shutdown;
    logic [31:0] rdata;
    logic [13:0] dac_code_a, dac_code_b;
    int          num_errors = 0;
    int          checks_done = 0;
    int          cyc = 0;
    // o packs code a, code b, speed, shutdown
    dsl_row_t rows [14] = '{'{24, 32'h0050FFFF, 32'h00000004}, '{32, 32'hA53048D3, 32'h48D00004},
        '{24, 32'h0001FFFC, 32'h48D00004}, '{24, 32'h00110000, 32'h48D3FFF4},
        '{24, 32'h000F0004, 32'h48D3FFF4}, '{24, 32'h0020AAA8, 32'hAAA80014},
        '{24, 32'h004F0000, 32'hAAA80017}, '{24, 32'h00700000, 32'hAAA80017},
        '{24, 32'h00100000, 32'hAAA80016}, '{32, 32'h5A3200AC, 32'hAAA80016},
        '{24, 32'h00600000, 32'hAAA80012}, '{24, 32'h005F0000, 32'hAAA8001E},
        '{24, 32'h00400000, 32'hAAA8001F}, '{24, 32'h00F00000, 32'hAAA8001F}};
    dsl_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .serial_clk(sclk), .serial_in(sin), .select_load_n(sel_n), .serial_out(sout),
        .async_zero_in(clr), .dac_code_a(dac_code_a), .dac_code_b(dac_code_b),
        .dac_fast(dac_fast), .dac_shutdown(dac_shutdown));
    dsl_host_model host_u (.serial_clk(sclk), .serial_in(sin), .select_load_n(sel_n),
        .serial_out(sout));
    initial begin
        forever #5 aclk = ~aclk;
    end
    ////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        logic ah, wh;
        ah = 1'b0;
        wh = 1'b0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(ah && wh)) begin
            @(negedge aclk);
            ah = ah || (awvalid && awready === 1'b1);
            wh = wh || (wvalid && wready === 1'b1);
            @(posedge aclk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
        end
        do @(negedge aclk); while (bvalid !== 1'b1);
        check({30'h0, bresp}, 32'h0);
        @(posedge aclk);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        v = rdata;
        check({30'h0, rresp}, 32'h0);
        @(posedge aclk);
        rready <= 1'b0;
    endtask
    task automatic do_reset();
        aresetn <= 1'b0;
        host_u.pump(3);
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        host_u.pump(3);
        repeat (2) @(posedge aclk);
    endtask
    function automatic logic [31:0] outs();
        return {dac_code_a, dac_code_b, dac_fast, dac_shutdown};
    endfunction
    ////////////////////////////////////////
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            summarize();
        end
    end
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, clr} = 6'h0;
        awaddr = 4'h0;
        araddr = 4'h0;
        wdata = 32'h0;
        sh = 32'h0;
        do_reset();
        check(outs(), 32'h0);
        rd(4'h0, d);
        check(d & 32'h3, 32'h1);
        foreach (rows[i]) begin
            d = sh >> (32 - rows[i].n);
            host_u.send(rows[i].w, rows[i].n, so);
            sh = (rows[i].n == 6'd32) ? rows[i].w : {sh[7:0], rows[i].w[23:0]};
            repeat (10) @(posedge aclk);
            check(so, d);
            check(outs(), rows[i].o);
            $display("frame %0d done", i);
        end
        rd(4'h4, d);
        check(d, 32'hEAAA2AAA);
        rd(4'hC, d);
        check(d, 32'h0EF00000);
        wr(4'h0, 32'h0);
        host_u.send(32'h00300004, 24, so);
        repeat (10) @(posedge aclk);
        wr(4'h0, 32'h1);
        wr(4'h4, 32'h0);
        check(outs(), 32'hAAA8001F);
        $display("disable test done");
        clr <= 1'b1;
        repeat (5) @(posedge aclk);
        check(outs(), 32'h0000000F);
        clr <= 1'b0;
        host_u.send(32'h00303FFC, 24, so);
        repeat (10) @(posedge aclk);
        check(outs(), 32'h3FFC000E);
        wr(4'h0, 32'h3);
        repeat (6) @(posedge aclk);
        check(outs(), 32'h0000000E);
        $display("clear test done");
        do_reset();
        check(outs(), 32'h0);
        host_u.send(32'h12345678, 32, so);
        check(so, 32'h0);
        $display("reset test done");
        summarize();
    end
endmodule
